/* File: hw/acsr_regs.vh */
// Purpose: Offsets, field positions and reset values of the serial register bank
// Assumes: 15-bit register addresses, 8-bit registers
// Notes:   Included by the bank module only
`ifndef ACSR_REGS_VH
`define ACSR_REGS_VH

// Register offsets
`define ACSR_ADDR_IFACE_B      15'h0001
`define ACSR_ADDR_MAKER_HIGH   15'h000d
`define ACSR_ADDR_STREAM_WRAP  15'h000e
`define ACSR_ADDR_IFACE_C      15'h0010
`define ACSR_ADDR_FAULT_FLAGS  15'h0011
`define ACSR_ADDR_LEAVE_SETUP  15'h0014
`define ACSR_ADDR_AVERAGER     15'h0015
`define ACSR_ADDR_BIAS_LOW     15'h0016
`define ACSR_ADDR_BIAS_MID     15'h0017
`define ACSR_ADDR_BIAS_HIGH    15'h0018

// Field positions
`define ACSR_SINGLE_CMD_BIT    7
`define ACSR_SCLK_FAULT_BIT    4
`define ACSR_LEAVE_SETUP_BIT   0
`define ACSR_AVG_RESTART_BIT   7
`define ACSR_AVG_LEN_MSB       4

// Reset values
`define ACSR_RST_BYTE          8'h00
`define ACSR_RST_BIAS          24'h000000

// Frame geometry: instruction bits and least legal frame length
`define ACSR_INSTR_BITS        16'h0010
`define ACSR_MIN_FRAME_BITS    16'h0018

`endif

/* File: hw/acsr_bank.v */
// Purpose: Serial register bank for stream control, fault flags, setup exit,
//          averager control and the channel 0 correction bias
// Assumes: Serial mode 0, instruction = R/W bit plus 15-bit address, MSB first;
//          link pins are sampled by sys_clk, which must run well above sclk
// Notes:   Streaming steps the address down; 0x0e loops it back for one frame
//          Exit from setup mode is one-way until the next reset
//          Length codes above 0x10 are stored as written
//          Host writes land only while a frame is open; frame end can clear the wrap length or set the count fault
`timescale 1ns/1ps
`include "acsr_regs.vh"

module acsr_bank #(
  parameter [7:0] MAKER_CODE_HIGH = 8'h5a   // Arbitrary neutral value
) (
  input  wire        sys_clk,               // 250 MHz system clock
  input  wire        rst,                   // Async reset, active high
  input  wire        sclk,                  // Serial clock from host
  input  wire        cs_n,                  // Chip select, active low
  input  wire        sdi,                   // Serial data in
  output reg         sdo,                   // Serial data out
  output reg         sdo_oe,                // High while sdo is driven
  output reg         config_mode,           // High while in register setup mode
  output reg         averager_restart,      // One-cycle filter reset pulse
  output reg  [4:0]  averager_log2_length,  // Averager block length code
  output reg  [23:0] ch0_correction_bias    // Signed channel 0 bias
);

  // Link pins as one vector: bit 0 clock, bit 1 chip select, bit 2 data
  // All three take the same two-clock path, so their skew stays as launched
  wire [2:0] pin_raw = {sdi, cs_n, sclk};
  wire [2:0] pin_sync;
  reg        sclk_last_q;
  reg        cs_last_q;

  // Two-stage synchronisers; only the second stage feeds logic
  // Chip select resets high so no false frame start follows reset
  genvar si;
  generate
    for (si = 0; si < 3; si = si + 1) begin : g_pin_sync
      reg [1:0] stage_q;
      always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          stage_q <= (si == 1) ? 2'h3 : 2'h0;
        end else begin
          stage_q <= {stage_q[0], pin_raw[si]};
        end
      end
      assign pin_sync[si] = stage_q[1];
    end
  endgenerate

  // Previous synchronised levels, for edge detection
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sclk_last_q <= 1'b0;
      cs_last_q   <= 1'b1;
    end else begin
      sclk_last_q <= pin_sync[0];
      cs_last_q   <= pin_sync[1];
    end
  end

  // Edge events on the sampled link
  wire sclk_rise  = pin_sync[0] & ~sclk_last_q & ~pin_sync[1];
  wire sclk_fall  = ~pin_sync[0] & sclk_last_q & ~pin_sync[1];
  wire frame_beg  = ~pin_sync[1] & cs_last_q;
  wire frame_end  = pin_sync[1] & ~cs_last_q;
  wire sdi_bit    = pin_sync[2];

  // Register storage
  reg        single_cmd_q;
  reg [7:0]  stream_wrap_q;
  reg        stream_written_q;
  reg [7:0]  loop_len_q;
  reg        sclk_fault_q;
  reg        leave_setup_q;
  reg [4:0]  avg_len_q;
  // Bias bytes come from the generate loop further down
  wire [23:0] bias_q;

  // Frame state
  reg [15:0] bit_cnt_q;
  reg [15:0] shift_q;
  reg        rd_q;
  reg [14:0] addr_q;
  reg [14:0] start_addr_q;
  reg [7:0]  byte_num_q;
  reg        data_done_q;
  reg [7:0]  tx_q;

  // Read decode, used for the first byte and every streamed byte
  // Unmapped and reserved addresses read zero
  function [7:0] read_reg;
    input [14:0] a;
    begin
      case (a)
        `ACSR_ADDR_IFACE_B:     read_reg = {single_cmd_q, 7'h00};
        `ACSR_ADDR_MAKER_HIGH:  read_reg = MAKER_CODE_HIGH;
        `ACSR_ADDR_STREAM_WRAP: read_reg = stream_wrap_q;
        `ACSR_ADDR_FAULT_FLAGS: read_reg = {3'h0, sclk_fault_q, 4'h0};
        `ACSR_ADDR_LEAVE_SETUP: read_reg = {7'h00, leave_setup_q};
        `ACSR_ADDR_AVERAGER:    read_reg = {3'h0, avg_len_q};
        `ACSR_ADDR_BIAS_LOW:    read_reg = bias_q[7:0];
        `ACSR_ADDR_BIAS_MID:    read_reg = bias_q[15:8];
        `ACSR_ADDR_BIAS_HIGH:   read_reg = bias_q[23:16];
        default:                read_reg = 8'h00;
      endcase
    end
  endfunction

  // Frame timing, in system clocks:
  //   pins reach logic two clocks late, so edges are seen late but in order
  //   the instruction ends on the sixteenth rising clock
  //   each data byte ends on every eighth rise after that
  //   read bits leave on falling clocks, half a period before the host samples
  //   chip select rising closes the frame and judges the clock count
  // Byte boundaries within the frame
  wire        instr_done = sclk_rise & (bit_cnt_q == (`ACSR_INSTR_BITS - 16'h0001));
  wire        byte_done  = sclk_rise & (bit_cnt_q >= (`ACSR_MIN_FRAME_BITS - 16'h0001))
                           & (bit_cnt_q[2:0] == 3'h7);
  wire [7:0]  rx_byte    = {shift_q[6:0], sdi_bit};
  wire        wr_now     = byte_done & ~rd_q & ~data_done_q;
  wire        bad_count  = (bit_cnt_q != 16'h0000) &
                           ((bit_cnt_q < `ACSR_MIN_FRAME_BITS) | (bit_cnt_q[2:0] != 3'h0));
  // Shift a read bit out on a falling clock once the instruction is in
  wire        shift_out  = sclk_fall & rd_q & (bit_cnt_q >= `ACSR_INSTR_BITS) & ~data_done_q;

  // Streaming steps down by one; zero wrap length lets it roll through 0x0000
  // Loop back uses the count latched at frame start, never a mid-frame write
  // Address after a data byte: loop back, hold, or step down
  reg [14:0] next_addr;
  reg [7:0]  next_num;
  always @* begin
    next_num  = byte_num_q + 8'h01;
    next_addr = addr_q - 15'h0001;
    if (single_cmd_q) begin
      next_addr = addr_q;
    end else if ((loop_len_q != 8'h00) && (next_num == loop_len_q)) begin
      next_addr = start_addr_q;
      next_num  = 8'h00;
    end
  end

  // Loop length is latched at frame start, so a fresh write acts one frame later
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      loop_len_q <= 8'h00;
    end else if (frame_beg) begin
      loop_len_q <= stream_wrap_q;
    end
  end

  // Bit counter and input shifter; the count is judged when chip select rises
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      bit_cnt_q <= 16'h0000;
      shift_q   <= 16'h0000;
    end else if (frame_beg) begin
      // Frame start clears the count even if a stray clock preceded it
      bit_cnt_q <= 16'h0000;
    end else if (sclk_rise) begin
      shift_q <= {shift_q[14:0], sdi_bit};
      // Saturate so a runaway frame still reads as faulty
      if (bit_cnt_q != 16'hffff)
        bit_cnt_q <= bit_cnt_q + 16'h0001;
    end
  end

  // Address, byte position and the byte queued for the read pin
  // Addresses step only on data byte boundaries, never mid-byte
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rd_q         <= 1'b0;
      addr_q       <= 15'h0000;
      start_addr_q <= 15'h0000;
      byte_num_q   <= 8'h00;
      data_done_q  <= 1'b0;
      tx_q         <= 8'h00;
    end else begin
      if (frame_beg) begin
        byte_num_q  <= 8'h00;
        data_done_q <= 1'b0;
      end
      // Reads are loaded a byte ahead so the first bit is ready on the next fall
      if (instr_done) begin
        rd_q         <= shift_q[14];
        addr_q       <= {shift_q[13:0], sdi_bit};
        start_addr_q <= {shift_q[13:0], sdi_bit};
        tx_q         <= read_reg({shift_q[13:0], sdi_bit});
      end else if (byte_done) begin
        // Single mode takes one data byte and ignores the rest
        data_done_q <= single_cmd_q;
        addr_q      <= next_addr;
        byte_num_q  <= next_num;
        tx_q        <= read_reg(next_addr);
      end else if (shift_out) begin
        tx_q <= {tx_q[6:0], 1'b0};
      end
      if (frame_end)
        rd_q <= 1'b0;
    end
  end

  // Read pin: one bit per falling clock, enable dropped once chip select is high
  // Unread bytes simply stop shifting; the pin keeps its last bit until frame end
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sdo    <= 1'b0;
      sdo_oe <= 1'b0;
    end else begin
      if (shift_out) begin
        sdo    <= tx_q[7];
        sdo_oe <= 1'b1;
      end
      if (frame_end)
        sdo_oe <= 1'b0;
    end
  end

  // Write strobe for one register, shared by the register processes below
  function wr_hit;
    input [14:0] a;
    begin
      wr_hit = wr_now & (addr_q == a);
    end
  endfunction

  // Single-command select; the other bits of this byte are not kept
  // Reset value selects streaming
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      single_cmd_q <= 1'b0;
    end else if (wr_hit(`ACSR_ADDR_IFACE_B)) begin
      single_cmd_q <= rx_byte[`ACSR_SINGLE_CMD_BIT];
    end
  end

  // Wrap length; a frame that writes it keeps it for the next frame only
  // A write needs chip select low, so it never meets frame end in one cycle
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      stream_wrap_q    <= `ACSR_RST_BYTE;
      stream_written_q <= 1'b0;
    end else begin
      if (wr_hit(`ACSR_ADDR_STREAM_WRAP)) begin
        stream_wrap_q    <= rx_byte;
        stream_written_q <= 1'b1;
      end
      if (frame_end) begin
        if (!stream_written_q)
          stream_wrap_q <= 8'h00;
        stream_written_q <= 1'b0;
      end
    end
  end

  // Count fault: a set at frame end beats a clear by the host in the same cycle
  // Zero-clock frames are not counted as faults
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sclk_fault_q <= 1'b0;
    end else if (frame_end & bad_count) begin
      sclk_fault_q <= 1'b1;
    end else if (wr_hit(`ACSR_ADDR_FAULT_FLAGS) & rx_byte[`ACSR_SCLK_FAULT_BIT]) begin
      sclk_fault_q <= 1'b0;
    end
  end

  // Exit bit holds until chip select rises, then setup mode ends
  // Setup mode has no way back short of a reset
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      leave_setup_q <= 1'b0;
      config_mode   <= 1'b1;
    end else if (frame_end & leave_setup_q) begin
      leave_setup_q <= 1'b0;
      config_mode   <= 1'b0;
    end else if (wr_hit(`ACSR_ADDR_LEAVE_SETUP) & rx_byte[`ACSR_LEAVE_SETUP_BIT]) begin
      leave_setup_q <= 1'b1;
    end
  end

  // Averager: the restart bit is never stored, it only makes a one-cycle pulse
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      avg_len_q            <= 5'h00;
      averager_restart     <= 1'b0;
      averager_log2_length <= 5'h00;
    end else begin
      averager_restart <= 1'b0;
      if (wr_hit(`ACSR_ADDR_AVERAGER)) begin
        // Codes 0x11 to 0x1f are kept as written; the host must avoid them
        avg_len_q        <= rx_byte[`ACSR_AVG_LEN_MSB:0];
        averager_restart <= rx_byte[`ACSR_AVG_RESTART_BIT];
      end
      // Pin copy lags the stored field by one clock
      averager_log2_length <= avg_len_q;
    end
  end

  // Three bias bytes at consecutive offsets, one process each
  genvar bi;
  generate
    for (bi = 0; bi < 3; bi = bi + 1) begin : g_bias_byte
      localparam [14:0] byte_addr = (bi == 0) ? `ACSR_ADDR_BIAS_LOW :
                                    (bi == 1) ? `ACSR_ADDR_BIAS_MID :
                                                `ACSR_ADDR_BIAS_HIGH;
      reg [7:0] byte_q;
      always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          byte_q <= `ACSR_RST_BYTE;
        end else if (wr_hit(byte_addr)) begin
          byte_q <= rx_byte;
        end
      end
      assign bias_q[8*bi +: 8] = byte_q;
    end
  endgenerate

  // Output copy of the bias, so the pin comes straight from a flop
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ch0_correction_bias <= `ACSR_RST_BIAS;
    end else begin
      ch0_correction_bias <= bias_q;
    end
  end

endmodule // acsr_bank

/* File: tb/acsr_host.sv */
// Purpose: Host model driving the serial link in mode 0, MSB first
// Assumes: sclk period 32 ns, four sys_clk low then four high
// Notes:   sdi shows the inverse of its last bit between frames
`timescale 1ns/1ps
module acsr_host (
  input  wire sys_clk,  // System clock
  output reg  sclk,     // Serial clock, idle low
  output reg  cs_n,     // Chip select, active low
  output reg  sdi,      // Serial data to device
  input  wire sdo       // Serial data from device
);
  // Idle levels at time zero
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sdi = 1'b0;
  end
  // Sample late in the high phase, since sdo moves a few cycles after each fall
  task frame(input [47:0] bits, input integer nbits, output [31:0] rdata);
    integer i;
    begin
      rdata = 32'h0;
      @(posedge sys_clk) cs_n <= 1'b0;
      for (i = 0; i < nbits; i = i + 1) begin
        sdi <= bits[47 - i];
        repeat (4) @(posedge sys_clk);
        sclk <= 1'b1;
        repeat (4) @(posedge sys_clk);
        if (i >= 16) rdata = {rdata[30:0], sdo};
        sclk <= 1'b0;
      end
      repeat (8) @(posedge sys_clk);
      cs_n <= 1'b1;
      sdi <= ~sdi;
      repeat (8) @(posedge sys_clk);
    end
  endtask
endmodule // acsr_host

/* File: tb/acsr_bank_chk.sv */
// Purpose: Port-level checks of the serial register bank
// Assumes: Register writes land only while a frame is open
// Notes:   Attached by bind
`timescale 1ns/1ps
module acsr_bank_chk (
  input wire        sys_clk,              // System clock
  input wire        rst,                  // Async reset
  input wire        sclk,                 // Serial clock
  input wire        cs_n,                 // Chip select
  input wire        sdi,                  // Serial data in
  input wire        sdo,                  // Serial data out
  input wire        sdo_oe,               // Output enable
  input wire        config_mode,          // Setup mode
  input wire        averager_restart,     // Restart pulse
  input wire [4:0]  averager_log2_length, // Length code
  input wire [23:0] ch0_correction_bias   // Bias word
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_restart_one_pulse: assert property (averager_restart |=> !averager_restart)
    else $error("restart pulse longer than one cycle");
  a_restart_in_frame: assert property (averager_restart |-> !cs_n)
    else $error("restart outside a frame");
  a_len_in_frame: assert property ($changed(averager_log2_length) |-> !cs_n)
    else $error("length changed outside a frame");
  a_bias_in_frame: assert property ($changed(ch0_correction_bias) |-> !cs_n)
    else $error("bias changed outside a frame");
  a_setup_no_return: assert property (!config_mode |=> !config_mode)
    else $error("setup mode re-entered");
  a_setup_exit_cs: assert property ($fell(config_mode) |-> cs_n && $past(cs_n))
    else $error("setup exit before chip select high");
  a_oe_idle_off: assert property (cs_n [*6] |-> !sdo_oe)
    else $error("sdo driven between frames");
  a_oe_rise_frame: assert property ($rose(sdo_oe) |-> !cs_n)
    else $error("sdo enabled outside a frame");
  c_restart: cover property (averager_restart);
  c_exit: cover property ($fell(config_mode));
  c_read: cover property ($rose(sdo_oe));
endmodule // acsr_bank_chk
bind acsr_bank acsr_bank_chk chk (.*);

/* File: tb/tb.sv */
// Purpose: Self-checking bench for the serial register bank
// Assumes: Host model frames every access
// Notes:   Setup exit runs last, it has no way back
`timescale 1ns/1ps
module tb;
  reg         sys_clk;
  reg         rst;
  wire        sclk, cs_n, sdi, sdo, sdo_oe, config_mode, averager_restart;
  wire [4:0]  averager_log2_length;
  wire [23:0] ch0_correction_bias;
  reg  [31:0] rd;
  reg  [23:0] pulses;
  reg  [23:0] p0;
  integer     fail_count;
  integer     checked;
  acsr_bank #(.MAKER_CODE_HIGH(8'h3c)) uut (.sys_clk(sys_clk), .rst(rst), .sclk(sclk),
    .cs_n(cs_n), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe), .config_mode(config_mode),
    .averager_restart(averager_restart), .averager_log2_length(averager_log2_length),
    .ch0_correction_bias(ch0_correction_bias));
  acsr_host host (.sys_clk(sys_clk), .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo));
  // Clock, 4 ns period
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  // Count restart pulses
  always @(posedge sys_clk) if (rst) pulses <= 24'h0; else if (averager_restart) pulses <= pulses + 1;
  task chk(input [23:0] got, input [23:0] exp);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        fail_count = fail_count + 1;
        $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task wr(input [14:0] a, input [31:0] d, input integer nb);
    host.frame({1'b0, a, d}, 16 + 8 * nb, rd);
  endtask
  task rdb(input [14:0] a, input integer nb);
    host.frame({1'b1, a, 32'h0}, 16 + 8 * nb, rd);
  endtask
  task print_verdict;
    begin
      if (fail_count == 0 && checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
    end
  endtask
  task test_maker;
    begin
      rdb(15'h0d, 1);
      chk({16'h0, rd[7:0]}, 24'h3c);
      wr(15'h0d, 32'ha5000000, 1);
      rdb(15'h0d, 1);
      chk({16'h0, rd[7:0]}, 24'h3c);
    end
  endtask
  task test_bias;
    begin
      wr(15'h18, 32'h80123400, 3);
      chk(ch0_correction_bias, 24'h801234);
      rdb(15'h18, 3);
      chk(rd[23:0], 24'h801234);
    end
  endtask
  task test_wrap;
    begin
      wr(15'h0e, 32'h02000000, 1);
      wr(15'h18, 32'h11223344, 4);
      chk(ch0_correction_bias, 24'h334434);
      wr(15'h0e, 32'hff000000, 1);
      rdb(15'h0e, 1);
      chk({16'h0, rd[7:0]}, 24'hff);
      rdb(15'h0e, 1);
      chk({16'h0, rd[7:0]}, 24'h0);
    end
  endtask
  task test_avg;
    begin
      p0 = pulses;
      wr(15'h15, 32'hf0000000, 1);                   // Restart bit plus legal length code 0x10
      chk(pulses - p0, 24'h1);
      chk({19'h0, averager_log2_length}, 24'h10);
      rdb(15'h15, 1);
      chk({16'h0, rd[7:0]}, 24'h10);
      wr(15'h15, 32'h00000000, 1);
      chk({19'h0, averager_log2_length}, 24'h0);
      chk(pulses - p0, 24'h1);
    end
  endtask
  task test_fault;
    begin
      host.frame({1'b0, 15'h000a, 32'h55000000}, 27, rd);
      rdb(15'h11, 1);
      chk({16'h0, rd[7:0]}, 24'h10);
      wr(15'h11, 32'hef000000, 1);
      rdb(15'h11, 1);
      chk({16'h0, rd[7:0]}, 24'h10);
      wr(15'h11, 32'h10000000, 1);
      rdb(15'h11, 1);
      chk({16'h0, rd[7:0]}, 24'h0);
    end
  endtask
  task test_single;
    begin
      wr(15'h01, 32'h80000000, 1);
      wr(15'h18, 32'haabbcc00, 3);
      chk(ch0_correction_bias, 24'haa4434);
      rdb(15'h01, 1);
      chk({16'h0, rd[7:0]}, 24'h80);
      wr(15'h01, 32'h00000000, 1);
      wr(15'h17, 32'h01020300, 2);
      chk(ch0_correction_bias, 24'haa0102);
      chk({23'h0, sdo_oe}, 24'h0);
    end
  endtask
  task test_exit;
    begin
      chk({23'h0, config_mode}, 24'h1);
      wr(15'h14, 32'h01000000, 1);
      chk({23'h0, config_mode}, 24'h0);
      rdb(15'h14, 1);
      chk({16'h0, rd[7:0]}, 24'h0);
    end
  endtask
  // Main sequence after a four-cycle reset
  initial begin
    fail_count = 0;
    checked = 0;
    rst = 1'b1;
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (6) @(posedge sys_clk);
    test_maker;
    test_bias;
    test_wrap;
    test_avg;
    test_fault;
    test_single;
    test_exit;
    print_verdict;
  end
  // Watchdog, well beyond the twenty-odd frames
  initial begin
    #100000;
    fail_count = fail_count + 1;
    print_verdict;
  end
endmodule // tb
